// ### hdl/slts_pkg.sv
package slts_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [11:0] IDX_LINK_EN = 12'h200;
	localparam logic [11:0] IDX_TEST = 12'h205;
	localparam logic [11:0] IDX_DID = 12'h206;
	localparam logic [11:0] IDX_FRAME_END_CHAR_SELECT = 12'h207;
	localparam logic [11:0] IDX_STATUS = 12'h208;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h210;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h211;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic LINK_EN_RST = 1'h1;
	localparam logic [3:0] TEST_RST = 4'h0;
	localparam logic [7:0] DID_RST = 8'h00;
	localparam logic [1:0] FRAME_END_CHAR_SELECT_RST = 2'h0;
	localparam int ST_LINK = 6;
	localparam int ST_SYNC = 5;
	localparam int ST_REALIGN = 4;
	localparam int ST_LMFC_PHASE_SET_FLAG = 3;
	localparam int ST_PLL = 2;
	localparam int IRQ_REALIGN = 0;
	localparam int IRQ_LMFC_PHASE_SET_FLAG = 1;

	// ---------------------------------------------------------------
	// Test pattern codes
	// ---------------------------------------------------------------
	localparam logic [3:0] TP_NORMAL = 4'h0;
	localparam logic [3:0] TP_PRBS7 = 4'h1;
	localparam logic [3:0] TP_PRBS15 = 4'h2;
	localparam logic [3:0] TP_PRBS23 = 4'h3;
	localparam logic [3:0] TP_RAMP = 4'h4;
	localparam logic [3:0] TP_TRANSPORT = 4'h5;
	localparam logic [3:0] TP_D21_5 = 4'h6;
	localparam logic [3:0] TP_K28_5 = 4'h7;
	localparam logic [3:0] TP_ILA = 4'h8;
	localparam logic [3:0] TP_RPAT = 4'h9;
	localparam logic [3:0] TP_LOW = 4'ha;
	localparam logic [3:0] TP_HIGH = 4'hb;

	// ---------------------------------------------------------------
	// Characters and framing
	// ---------------------------------------------------------------
	localparam logic [7:0] CH_K28_7 = 8'hfc;
	localparam logic [7:0] CH_K28_1 = 8'h3c;
	localparam logic [7:0] CH_K28_5 = 8'hbc;
	localparam logic [7:0] CH_K28_0 = 8'h1c;
	localparam logic [7:0] CH_K28_3 = 8'h7c;
	localparam logic [7:0] CH_K28_4 = 8'h9c;
	localparam logic [7:0] CH_D21_5 = 8'hb5;
	localparam logic [4:0] LMFC_LAST = 5'h1f;
	localparam logic [6:0] ILA_LAST = 7'h7f;
	localparam logic [1:0] ILA_MF_CFG = 2'h1;
	localparam logic [4:0] ILA_OCT_Q = 5'h01;
	localparam logic [4:0] ILA_OCT_DID = 5'h02;

	typedef struct packed {
		logic k;
		logic [7:0] d;
	} slts_char_t;

endpackage : slts_pkg

// ### hdl/slts_lfsr.sv
`timescale 1ns/1ps
module slts_lfsr #(
	parameter int W = 7,
	parameter int TAP = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control and output
	input wire logic run,
	output logic [7:0] octet
);

	logic [W-1:0] state_ff;
	logic [W-1:0] nxt_state;
	logic [W+7:0] padded;

	// ---------------------------------------------------------------
	// Eight shifts per cycle, one octet per lane character
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		if (run) begin
			for (int i = 0; i < 8; i++) begin
				nxt_state = {nxt_state[W-2:0],
					nxt_state[W-1] ^ nxt_state[TAP-1]};
			end
		end
	end

	// All-ones seed; all-zero would lock the generator
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			state_ff <= '1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Padding keeps the short generator from selecting past its top bit
	assign padded = {8'h00, state_ff};
	assign octet = padded[7:0];

endmodule : slts_lfsr

// ### hdl/slts_link_regs.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Pattern 0 passes data; 1-3 send PRBS7, PRBS15, PRBS23.
// - Patterns 4-7 send ramp, transport test, D21.5 stream, K28.5 stream.
// - Pattern 8 repeats the alignment sequence; 9 sends modified RPAT.
// - Pattern 10 holds outputs low, 11 high; 12-15 reserved.
// - Eight-bit identifier goes out in the second alignment multiframe.
// - Link A sends the identifier, link B the identifier plus one.
// - Identifier bit 0 ignored on write and reads zero.
// - Frame char select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - Frame-end character replaces a repeated last octet, not every frame.
// - Status bit 6 reads one while the link runs; read-only.
// - Status bit 5 follows SYNC~: zero while requested.
// - Status bit 4 set on a SYSREF realignment; write one clears.
// - Status bit 3 set by first SYSREF after enable; write one clears.
// - Status bit 2 shows PLL lock; bits 7 and 1-0 read zero.
// - Link disabled: held reset, serializers down, multiframe count held at zero.
module slts_link_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [13:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Link inputs
	input wire logic sync_n,
	input wire logic sysref,
	input wire logic pll_locked,
	input wire logic frame_end,
	input wire logic [7:0] data_a,
	input wire logic [7:0] data_b,
	// Lane outputs
	output slts_pkg::slts_char_t lane_a,
	output slts_pkg::slts_char_t lane_b,
	output logic ser_hold_low,
	output logic ser_hold_high,
	output logic ser_power_down,
	// Interrupt
	output logic irq
);

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	logic wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic access, wr_acc, rd_acc;
	logic [11:0] idx;

	assign access = (read || write) && wait_ff;
	assign wr_acc = access && write && byteenable[0];
	assign rd_acc = access && read;
	assign idx = address[13:2];

	// ---------------------------------------------------------------
	// Registers and status
	// ---------------------------------------------------------------
	logic link_en_ff, nxt_link_en;
	logic [3:0] test_ff, nxt_test;
	logic [7:0] did_ff, nxt_did;
	logic [1:0] frame_end_char_select_ff, nxt_frame_end_char_select;
	logic realign_ff, nxt_realign;
	logic lmfc_phase_set_flag_ff, nxt_lmfc_phase_set_flag;
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_mask_ff, nxt_irq_mask;
	logic irq_ff, nxt_irq;
	logic sync_ff, pll_ff, run_ff, nxt_run;
	logic [7:0] status;
	logic ev_realign, ev_lmfc_phase_set_flag;

	// ---------------------------------------------------------------
	// Link timing
	// ---------------------------------------------------------------
	logic [4:0] lmfc_ff, nxt_lmfc;
	logic lmfc_set_ff, nxt_lmfc_set;
	logic [6:0] ila_ff, nxt_ila;
	logic [7:0] ramp_ff, nxt_ramp;
	logic [7:0] tpl_ff, nxt_tpl;
	logic [7:0] last_a_ff, nxt_last_a;
	logic [7:0] last_b_ff, nxt_last_b;
	logic [7:0] did_b;
	logic [7:0] frame_end_char_select_code;
	logic [7:0] prbs7, prbs15, prbs23;
	slts_pkg::slts_char_t lane_a_ff, nxt_lane_a;
	slts_pkg::slts_char_t lane_b_ff, nxt_lane_b;
	logic hold_low_ff, nxt_hold_low;
	logic hold_high_ff, nxt_hold_high;
	logic pd_ff;

	assign did_b = did_ff + 8'h01;
	assign status = {1'b0, run_ff, sync_ff, realign_ff, lmfc_phase_set_flag_ff,
		pll_ff, 2'b00};

	always_comb begin
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		if (wait_ff && (read || write)) begin
			nxt_wait = 1'b0;
		end
		if (rd_acc) begin
			nxt_rdata = 32'h0000_0000;
			unique case (idx)
				slts_pkg::IDX_LINK_EN: nxt_rdata[0] = link_en_ff;
				slts_pkg::IDX_TEST: nxt_rdata[3:0] = test_ff;
				slts_pkg::IDX_DID: nxt_rdata[7:0] = did_ff;
				slts_pkg::IDX_FRAME_END_CHAR_SELECT: nxt_rdata[1:0] = frame_end_char_select_ff;
				slts_pkg::IDX_STATUS: nxt_rdata[7:0] = status;
				slts_pkg::IDX_IRQ_STAT: nxt_rdata[1:0] = irq_stat_ff;
				slts_pkg::IDX_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Sticky events
	// ---------------------------------------------------------------
	// SYSREF is ignored while disabled, so no event can fire then
	assign ev_lmfc_phase_set_flag = link_en_ff && sysref && !lmfc_set_ff;
	assign ev_realign = link_en_ff && sysref && lmfc_set_ff &&
		(lmfc_ff != 5'h00);

	always_comb begin
		nxt_link_en = link_en_ff;
		nxt_test = test_ff;
		nxt_did = did_ff;
		nxt_frame_end_char_select = frame_end_char_select_ff;
		nxt_realign = realign_ff;
		nxt_lmfc_phase_set_flag = lmfc_phase_set_flag_ff;
		nxt_irq_stat = irq_stat_ff;
		nxt_irq_mask = irq_mask_ff;
		if (wr_acc) begin
			unique case (idx)
				slts_pkg::IDX_LINK_EN: nxt_link_en = writedata[0];
				slts_pkg::IDX_TEST: nxt_test = writedata[3:0];
				slts_pkg::IDX_DID: nxt_did = {writedata[7:1], 1'b0};
				slts_pkg::IDX_FRAME_END_CHAR_SELECT: nxt_frame_end_char_select = writedata[1:0];
				slts_pkg::IDX_STATUS: begin
					// Only the two flags respond; zero bits keep them
					if (writedata[slts_pkg::ST_REALIGN]) begin
						nxt_realign = 1'b0;
					end
					if (writedata[slts_pkg::ST_LMFC_PHASE_SET_FLAG]) begin
						nxt_lmfc_phase_set_flag = 1'b0;
					end
				end
				slts_pkg::IDX_IRQ_MASK: nxt_irq_mask = writedata[1:0];
				default: nxt_irq_mask = irq_mask_ff;
			endcase
		end
		if (rd_acc && idx == slts_pkg::IDX_IRQ_STAT) begin
			nxt_irq_stat = 2'b00;
		end
		// Set after clear: an event in the clearing cycle survives
		if (ev_realign) begin
			nxt_realign = 1'b1;
			nxt_irq_stat[slts_pkg::IRQ_REALIGN] = 1'b1;
		end
		if (ev_lmfc_phase_set_flag) begin
			nxt_lmfc_phase_set_flag = 1'b1;
			nxt_irq_stat[slts_pkg::IRQ_LMFC_PHASE_SET_FLAG] = 1'b1;
		end
		nxt_irq = |(irq_stat_ff & irq_mask_ff);
		nxt_run = link_en_ff && pll_ff && sync_ff && lmfc_set_ff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			link_en_ff <= slts_pkg::LINK_EN_RST;
			test_ff <= slts_pkg::TEST_RST;
			did_ff <= slts_pkg::DID_RST;
			frame_end_char_select_ff <= slts_pkg::FRAME_END_CHAR_SELECT_RST;
			realign_ff <= 1'b0;
			lmfc_phase_set_flag_ff <= 1'b0;
			irq_stat_ff <= 2'b00;
			irq_mask_ff <= 2'b00;
			irq_ff <= 1'b0;
			run_ff <= 1'b0;
			sync_ff <= 1'b0;
			pll_ff <= 1'b0;
		end else begin
			link_en_ff <= nxt_link_en;
			test_ff <= nxt_test;
			did_ff <= nxt_did;
			frame_end_char_select_ff <= nxt_frame_end_char_select;
			realign_ff <= nxt_realign;
			lmfc_phase_set_flag_ff <= nxt_lmfc_phase_set_flag;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			irq_ff <= nxt_irq;
			run_ff <= nxt_run;
			sync_ff <= sync_n;
			pll_ff <= pll_locked;
		end
	end

	// ---------------------------------------------------------------
	// Pattern sources
	// ---------------------------------------------------------------
	slts_lfsr #(.W(7), .TAP(6)) u_prbs7 (
		.clk(clk),
		.rst(rst),
		.run(link_en_ff && test_ff == slts_pkg::TP_PRBS7),
		.octet(prbs7)
	);

	slts_lfsr #(.W(15), .TAP(14)) u_prbs15 (
		.clk(clk),
		.rst(rst),
		.run(link_en_ff && test_ff == slts_pkg::TP_PRBS15),
		.octet(prbs15)
	);

	slts_lfsr #(.W(23), .TAP(18)) u_prbs23 (
		.clk(clk),
		.rst(rst),
		.run(link_en_ff && test_ff == slts_pkg::TP_PRBS23),
		.octet(prbs23)
	);

	always_comb begin
		unique case (frame_end_char_select_ff)
			2'h1: frame_end_char_select_code = slts_pkg::CH_K28_1;
			2'h2: frame_end_char_select_code = slts_pkg::CH_K28_5;
			default: frame_end_char_select_code = slts_pkg::CH_K28_7;
		endcase
	end

	// One lane character; link identity enters through did and data
	function automatic slts_pkg::slts_char_t lane_char(
		input logic [7:0] link_device_identifier, input logic [7:0] data,
		input logic [7:0] last);
		slts_pkg::slts_char_t c;
		c = '{k: 1'b0, d: 8'h00};
		unique case (test_ff)
			slts_pkg::TP_NORMAL: begin
				c.d = data;
				if (frame_end && data == last) begin
					c = '{k: 1'b1, d: frame_end_char_select_code};
				end
			end
			slts_pkg::TP_PRBS7: c.d = prbs7;
			slts_pkg::TP_PRBS15: c.d = prbs15;
			slts_pkg::TP_PRBS23: c.d = prbs23;
			slts_pkg::TP_RAMP: c.d = ramp_ff;
			slts_pkg::TP_TRANSPORT: c.d = tpl_ff;
			slts_pkg::TP_D21_5: c.d = slts_pkg::CH_D21_5;
			slts_pkg::TP_K28_5: c = '{k: 1'b1, d: slts_pkg::CH_K28_5};
			slts_pkg::TP_ILA: begin
				c.d = {3'b000, ila_ff[4:0]};
				if (ila_ff[4:0] == 5'h00) begin
					c = '{k: 1'b1, d: slts_pkg::CH_K28_0};
				end else if (ila_ff[4:0] == slts_pkg::LMFC_LAST) begin
					c = '{k: 1'b1, d: slts_pkg::CH_K28_3};
				end else if (ila_ff[6:5] == slts_pkg::ILA_MF_CFG) begin
					if (ila_ff[4:0] == slts_pkg::ILA_OCT_Q) begin
						c = '{k: 1'b1, d: slts_pkg::CH_K28_4};
					end else if (ila_ff[4:0] == slts_pkg::ILA_OCT_DID) begin
						c.d = link_device_identifier;
					end
				end
			end
			slts_pkg::TP_RPAT: begin
				unique case (ramp_ff[2:0])
					3'h0: c.d = 8'hbe;
					3'h1: c.d = 8'hd7;
					3'h2: c.d = 8'h23;
					3'h3: c.d = 8'h47;
					3'h4: c.d = 8'h6b;
					3'h5: c.d = 8'h8f;
					3'h6: c.d = 8'hb3;
					3'h7: c.d = 8'h14;
				endcase
			end
			// Held levels are forced at the serializer; 12-15 send zero
			default: c.d = 8'h00;
		endcase
		return c;
	endfunction : lane_char

	// ---------------------------------------------------------------
	// Lane datapath
	// ---------------------------------------------------------------
	always_comb begin
		nxt_lmfc = 5'h00;
		nxt_lmfc_set = 1'b0;
		nxt_ila = 7'h00;
		nxt_ramp = 8'h00;
		nxt_tpl = 8'h00;
		nxt_last_a = 8'h00;
		nxt_last_b = 8'h00;
		nxt_lane_a = '{k: 1'b0, d: 8'h00};
		nxt_lane_b = '{k: 1'b0, d: 8'h00};
		nxt_hold_low = 1'b0;
		nxt_hold_high = 1'b0;
		if (link_en_ff) begin
			nxt_lmfc = sysref ? 5'h00 : lmfc_ff + 5'h01;
			nxt_lmfc_set = lmfc_set_ff || sysref;
			nxt_ila = (test_ff == slts_pkg::TP_ILA) ?
				ila_ff + 7'h01 : 7'h00;
			nxt_ramp = ramp_ff + 8'h01;
			nxt_tpl = frame_end ? tpl_ff + 8'h01 : tpl_ff;
			nxt_last_a = frame_end ? data_a : last_a_ff;
			nxt_last_b = frame_end ? data_b : last_b_ff;
			nxt_lane_a = lane_char(did_ff, data_a, last_a_ff);
			nxt_lane_b = lane_char(did_b, data_b, last_b_ff);
			nxt_hold_low = test_ff == slts_pkg::TP_LOW;
			nxt_hold_high = test_ff == slts_pkg::TP_HIGH;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lmfc_ff <= 5'h00;
			lmfc_set_ff <= 1'b0;
			ila_ff <= 7'h00;
			ramp_ff <= 8'h00;
			tpl_ff <= 8'h00;
			last_a_ff <= 8'h00;
			last_b_ff <= 8'h00;
			lane_a_ff <= '{k: 1'b0, d: 8'h00};
			lane_b_ff <= '{k: 1'b0, d: 8'h00};
			hold_low_ff <= 1'b0;
			hold_high_ff <= 1'b0;
			pd_ff <= 1'b1;
		end else begin
			lmfc_ff <= nxt_lmfc;
			lmfc_set_ff <= nxt_lmfc_set;
			ila_ff <= nxt_ila;
			ramp_ff <= nxt_ramp;
			tpl_ff <= nxt_tpl;
			last_a_ff <= nxt_last_a;
			last_b_ff <= nxt_last_b;
			lane_a_ff <= nxt_lane_a;
			lane_b_ff <= nxt_lane_b;
			hold_low_ff <= nxt_hold_low;
			hold_high_ff <= nxt_hold_high;
			pd_ff <= !link_en_ff;
		end
	end

	assign readdata = rdata_ff;
	assign waitrequest = wait_ff;
	assign lane_a = lane_a_ff;
	assign lane_b = lane_b_ff;
	assign ser_hold_low = hold_low_ff;
	assign ser_hold_high = hold_high_ff;
	assign ser_power_down = pd_ff;
	assign irq = irq_ff;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_normal_pass: assert property (@(posedge clk) disable iff (rst)
		link_en_ff && test_ff == slts_pkg::TP_NORMAL && !frame_end
		|=> lane_a_ff.d == $past(data_a) && !lane_a_ff.k)
		else $error("normal data not passed");
	a_d215_stream: assert property (@(posedge clk) disable iff (rst)
		link_en_ff && test_ff == slts_pkg::TP_D21_5
		|=> lane_a_ff == '{k: 1'b0, d: slts_pkg::CH_D21_5})
		else $error("D21.5 stream wrong");
	a_ila_ident: assert property (@(posedge clk) disable iff (rst)
		link_en_ff && test_ff == slts_pkg::TP_ILA &&
		ila_ff == {slts_pkg::ILA_MF_CFG, slts_pkg::ILA_OCT_DID}
		|=> lane_a_ff.d == $past(did_ff) && lane_b_ff.d == $past(did_b))
		else $error("identifier missing in alignment");
	a_hold_low: assert property (@(posedge clk) disable iff (rst)
		link_en_ff && test_ff == slts_pkg::TP_LOW
		|=> ser_hold_low && !ser_hold_high)
		else $error("outputs not held low");
	a_did_even: assert property (@(posedge clk) disable iff (rst)
		wr_acc && idx == slts_pkg::IDX_DID
		|=> did_ff == {$past(writedata[7:1]), 1'b0})
		else $error("identifier write wrong");
	a_frame_end_char_select_insert: assert property (@(posedge clk) disable iff (rst)
		link_en_ff && test_ff == slts_pkg::TP_NORMAL && frame_end &&
		data_a == last_a_ff && frame_end_char_select_ff == 2'h0
		|=> lane_a_ff == '{k: 1'b1, d: slts_pkg::CH_K28_7})
		else $error("frame end character not inserted");
	a_sync_read: assert property (@(posedge clk) disable iff (rst)
		rd_acc && idx == slts_pkg::IDX_STATUS
		|=> readdata[slts_pkg::ST_SYNC] == $past(sync_ff))
		else $error("sync status wrong");
	a_realign_set: assert property (@(posedge clk) disable iff (rst)
		ev_realign |=> realign_ff && irq_stat_ff[slts_pkg::IRQ_REALIGN])
		else $error("realign flag not set");
	a_zero_keeps: assert property (@(posedge clk) disable iff (rst)
		wr_acc && idx == slts_pkg::IDX_STATUS && lmfc_phase_set_flag_ff &&
		!writedata[slts_pkg::ST_LMFC_PHASE_SET_FLAG] |=> lmfc_phase_set_flag_ff)
		else $error("lmfc_phase_set_flag flag lost");
	a_link_off: assert property (@(posedge clk) disable iff (rst)
		!link_en_ff |=> ser_power_down && lmfc_ff == 5'h00 &&
		!lmfc_set_ff && lane_a_ff.d == 8'h00)
		else $error("disabled link not held");
	a_wait_one: assert property (@(posedge clk) disable iff (rst)
		(read || write) && wait_ff |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest timing wrong");

endmodule : slts_link_regs

// ### verification/slts_rx_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-end receiver model
// ----------------------------------------
module slts_rx_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Lane and sync control
	input wire slts_pkg::slts_char_t lane_a,
	input wire logic sync_req,
	output logic sync_n,
	output logic [7:0] k_cnt
);
	// Holds sync requested through reset, as a real receiver does
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_n <= 1'h0;
			k_cnt <= 8'h00;
		end else begin
			sync_n <= ~sync_req;
			k_cnt <= k_cnt + {7'h00, lane_a.k};
		end
	end
endmodule : slts_rx_model

// ### verification/serial_link_test_and_status_tb.sv
`timescale 1ns/1ps
module serial_link_test_and_status_tb;
	logic clk, rst, read, write, sync_n, sysref, pll_locked, frame_end;
	logic [13:0] address;
	logic [31:0] writedata, readdata, x;
	logic [3:0] byteenable;
	logic [7:0] data_a, data_b, k_cnt, k0;
	logic waitrequest, ser_hold_low, ser_hold_high, ser_power_down, irq;
	logic sync_req;
	slts_pkg::slts_char_t lane_a, lane_b;
	int error_cnt = 0;
	int num_checks = 0;
	logic [3:0] pc [4] = '{4'h6, 4'h7, 4'ha, 4'hb};
	logic [8:0] pe [4] = '{9'h0b5, 9'h1bc, 9'h000, 9'h000};
	logic [7:0] fe [3] = '{8'hfc, 8'h3c, 8'hbc};

	slts_link_regs i_slts_link_regs (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .sync_n(sync_n),
		.sysref(sysref), .pll_locked(pll_locked), .frame_end(frame_end),
		.data_a(data_a), .data_b(data_b), .lane_a(lane_a), .lane_b(lane_b),
		.ser_hold_low(ser_hold_low), .ser_hold_high(ser_hold_high),
		.ser_power_down(ser_power_down), .irq(irq));
	slts_rx_model i_slts_rx_model (.clk(clk), .rst(rst), .lane_a(lane_a),
		.sync_req(sync_req), .sync_n(sync_n), .k_cnt(k_cnt));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [11:0] idx,
		input logic [7:0] wd, input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		address <= {idx, 2'h0};
		read <= ~w;
		write <= w;
		writedata <= {24'h000000, wd};
		byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 50);
		chk("waitrequest", 32'h0, {31'h0, waitrequest});
		rd = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask : bus

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		bus(1'h1, idx, d, 4'h1, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [11:0] idx,
		input logic [7:0] e);
		bus(1'h0, idx, 8'h00, 4'h0, x);
		chk(nm, {24'h0, e}, x);
	endtask : rdc

	task automatic lanes(input logic [8:0] ea, input logic [8:0] eb);
		@(negedge clk);
		chk("lane_a", {23'h0, ea}, {23'h0, lane_a});
		chk("lane_b", {23'h0, eb}, {23'h0, lane_b});
	endtask : lanes

	// Settings change only with the link off
	task automatic setreg(input logic [11:0] idx, input logic [7:0] d);
		wr(slts_pkg::IDX_LINK_EN, 8'h00);
		wr(idx, d);
		wr(slts_pkg::IDX_LINK_EN, 8'h01);
	endtask : setreg

	task automatic sref;
		@(posedge clk);
		sysref <= 1'h1;
		@(posedge clk);
		sysref <= 1'h0;
	endtask : sref

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("[FAIL] watchdog expected finish seen timeout");
		results();
	end

	initial begin
		rst = 1'h1; read = 1'h0; write = 1'h0; address = 14'h0000;
		writedata = 32'h0; byteenable = 4'h0; sync_req = 1'h0;
		sysref = 1'h0; pll_locked = 1'h0; frame_end = 1'h0;
		data_a = 8'h00; data_b = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rdc("link_en", slts_pkg::IDX_LINK_EN, 8'h01);
		rdc("test", slts_pkg::IDX_TEST, 8'h00);
		rdc("did", slts_pkg::IDX_DID, 8'h00);
		rdc("frame_end_char_select", slts_pkg::IDX_FRAME_END_CHAR_SELECT, 8'h00);
		rdc("mask", slts_pkg::IDX_IRQ_MASK, 8'h00);
		rdc("unmapped", 12'h3ff, 8'h00);
		wr(slts_pkg::IDX_LINK_EN, 8'h00);
		@(negedge clk);
		chk("power_down", 32'h1, {31'h0, ser_power_down});
		wr(slts_pkg::IDX_DID, 8'h35);
		rdc("did_even", slts_pkg::IDX_DID, 8'h34);
		wr(slts_pkg::IDX_TEST, 8'hff);
		rdc("test_field", slts_pkg::IDX_TEST, 8'h0f);
		bus(1'h1, slts_pkg::IDX_FRAME_END_CHAR_SELECT, 8'h02, 4'h0, x);
		rdc("frame_end_char_select_be", slts_pkg::IDX_FRAME_END_CHAR_SELECT, 8'h00);
		$display("test registers done");

		for (int i = 0; i < 4; i++) begin
			setreg(slts_pkg::IDX_TEST, {4'h0, pc[i]});
			repeat (3) @(posedge clk);
			lanes(pe[i], pe[i]);
			chk("hold_low", {31'h0, i == 2}, {31'h0, ser_hold_low});
			chk("hold_high", {31'h0, i == 3}, {31'h0, ser_hold_high});
		end
		setreg(slts_pkg::IDX_TEST, 8'h00);
		@(posedge clk);
		data_a <= 8'h5a;
		data_b <= 8'ha5;
		@(posedge clk);
		lanes(9'h05a, 9'h0a5);
		chk("power_up", 32'h0, {31'h0, ser_power_down});
		$display("test patterns done");
		k0 = k_cnt;

		// A repeated last octet is replaced; a fresh one passes
		for (int f = 0; f < 3; f++) begin
			setreg(slts_pkg::IDX_FRAME_END_CHAR_SELECT, 8'(f));
			@(posedge clk);
			frame_end <= 1'h1;
			data_a <= 8'h11;
			data_b <= 8'h11;
			@(posedge clk);
			data_a <= 8'h55;
			data_b <= 8'h55;
			@(posedge clk);
			lanes(9'h055, 9'h055);
			@(posedge clk);
			frame_end <= 1'h0;
			lanes({1'h1, fe[f]}, {1'h1, fe[f]});
		end
		setreg(slts_pkg::IDX_FRAME_END_CHAR_SELECT, 8'h00);
		chk("k_count", {24'h0, k0 + 8'h03}, {24'h0, k_cnt});
		$display("test frame char done");

		@(posedge clk);
		pll_locked <= 1'h1;
		repeat (3) @(posedge clk);
		wr(slts_pkg::IDX_STATUS, 8'h18);
		rdc("irq_clr", slts_pkg::IDX_IRQ_STAT, 8'h00);
		wr(slts_pkg::IDX_IRQ_MASK, 8'h02);
		sref();
		repeat (3) @(posedge clk);
		rdc("status", slts_pkg::IDX_STATUS, 8'h6c);
		@(negedge clk);
		chk("irq_set", 32'h1, {31'h0, irq});
		rdc("irq_stat", slts_pkg::IDX_IRQ_STAT, 8'h02);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		rdc("irq_rc", slts_pkg::IDX_IRQ_STAT, 8'h00);
		wr(slts_pkg::IDX_STATUS, 8'h00);
		rdc("w0_keep", slts_pkg::IDX_STATUS, 8'h6c);
		wr(slts_pkg::IDX_STATUS, 8'hc4);
		rdc("ro_keep", slts_pkg::IDX_STATUS, 8'h6c);
		wr(slts_pkg::IDX_STATUS, 8'h08);
		rdc("w1c_al", slts_pkg::IDX_STATUS, 8'h64);
		sref();
		wr(slts_pkg::IDX_STATUS, 8'h10);
		sref();
		repeat (2) @(posedge clk);
		rdc("realign", slts_pkg::IDX_STATUS, 8'h74);
		@(negedge clk);
		chk("irq_mask", 32'h0, {31'h0, irq});
		rdc("irq_re", slts_pkg::IDX_IRQ_STAT, 8'h01);
		wr(slts_pkg::IDX_STATUS, 8'h10);
		rdc("w1c_re", slts_pkg::IDX_STATUS, 8'h64);
		@(posedge clk);
		sync_req <= 1'h1;
		pll_locked <= 1'h0;
		repeat (4) @(posedge clk);
		bus(1'h0, slts_pkg::IDX_STATUS, 8'h00, 4'h0, x);
		chk("sync_bit", 32'h0, {31'h0, x[5]});
		chk("pll_bit", 32'h0, {31'h0, x[2]});
		chk("reserved", 32'h0, {29'h0, x[7], x[1:0]});
		@(posedge clk);
		sync_req <= 1'h0;
		pll_locked <= 1'h1;
		wr(slts_pkg::IDX_LINK_EN, 8'h00);
		wr(slts_pkg::IDX_STATUS, 8'h18);
		sref();
		repeat (2) @(posedge clk);
		bus(1'h0, slts_pkg::IDX_STATUS, 8'h00, 4'h0, x);
		chk("off_sysref", 32'h0, {30'h0, x[4:3]});
		lanes(9'h000, 9'h000);
		wr(slts_pkg::IDX_LINK_EN, 8'h01);
		sref();
		repeat (2) @(posedge clk);
		bus(1'h0, slts_pkg::IDX_STATUS, 8'h00, 4'h0, x);
		chk("first_sref", 32'h1, {31'h0, x[3]});
		$display("test status done");

		setreg(slts_pkg::IDX_TEST, {4'h0, slts_pkg::TP_ILA});
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if (lane_a === {1'h1, slts_pkg::CH_K28_4})
				break;
		end
		chk("ila_mark", {23'h0, 1'h1, slts_pkg::CH_K28_4}, {23'h0, lane_a});
		lanes(9'h034, 9'h035);
		$display("test alignment id done");
		results();
	end
endmodule : serial_link_test_and_status_tb
